/* logic/sfr_consts.svh */
// Constants for the bank 1 special register map: offsets, masks, reset values
`ifndef SFR_CONSTS_SVH
`define SFR_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register addresses, bank 1 view
// ----------------------------------------------------------------------------
`define SFR_ADR_INDIRECT    8'h80
`define SFR_ADR_OPTIONS     8'h81
`define SFR_ADR_PCL         8'h82
`define SFR_ADR_STATUS      8'h83
`define SFR_ADR_POINTER     8'h84
`define SFR_ADR_PORT_A_DIRECTION       8'h85
`define SFR_ADR_PORT_B_DIRECTION       8'h86
`define SFR_ADR_PORT_C_DIRECTION       8'h87
`define SFR_ADR_PORT_D_DIRECTION       8'h88
`define SFR_ADR_PORT_E_DIRECTION_SLAVE_FLAGS       8'h89
`define SFR_ADR_PCLATCH     8'h8a
`define SFR_ADR_INTCTL      8'h8b
`define SFR_ADR_PIE_ONE     8'h8c
`define SFR_ADR_PIE_TWO     8'h8d
`define SFR_ADR_PWRCAUSE    8'h8e
`define SFR_ADR_T2PERIOD    8'h92
`define SFR_ADR_SSPADR      8'h93
`define SFR_ADR_SSPSTATE    8'h94
`define SFR_ADR_TXCTL       8'h98
`define SFR_ADR_BAUD        8'h99
`define SFR_ADR_ANACFG      8'h9f

// ----------------------------------------------------------------------------
// Writable bit masks of the plain storage registers
// ----------------------------------------------------------------------------
`define SFR_WM_FULL         8'hff
`define SFR_WM_PORT_A_DIRECTION        8'h3f
`define SFR_WM_PORT_E_DIRECTION_SLAVE_FLAGS        8'h37
`define SFR_WM_PCLATCH      8'h1f
`define SFR_WM_PIE_TWO      8'h01
`define SFR_WM_TXCTL        8'hf5
`define SFR_WM_ANACFG       8'h07
`define SFR_WM_PWRCAUSE     8'h03
`define SFR_WM_NONE         8'h00

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SFR_RST_ONES        8'hff
`define SFR_RST_ZERO        8'h00
`define SFR_RST_PORT_A_DIRECTION       8'h3f
`define SFR_RST_PORT_E_DIRECTION_SLAVE_FLAGS       8'h07
`define SFR_RST_TXCTL       8'h02
`define SFR_RST_STATUS_CTL  5'h03

// ----------------------------------------------------------------------------
// Status and flag field positions
// ----------------------------------------------------------------------------
`define SFR_ST_TIMEOUT      4
`define SFR_ST_POWERDOWN    3
`define SFR_PORT_E_DIRECTION_SLAVE_FLAGS_IBF       7
`define SFR_PORT_E_DIRECTION_SLAVE_FLAGS_OBF       6
`define SFR_TX_SHIFT_EMPTY  1
`define SFR_BANK_ONE        2'b01
`define SFR_BANK_ZERO       2'b00

`endif

/* logic/sfr_pkg.sv */
// Types shared by the bank 1 special register map
package sfr_pkg;

  // Core data-memory access, direct file field plus strobes
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sfr_bus_req_t;

  // Cause of the reset that has just been released
  typedef struct packed {
    logic power_on;
    logic brown_out;
    logic watchdog;
    logic sleep;
  } sfr_cause_t;

  // Live state reported by peripherals into read-only bits, plus set pulses for the interrupt control flags
  typedef struct packed {
    logic       psp_in_full;
    logic       psp_out_full;
    logic       tx_shift_empty;
    logic [5:0] ssp_state;
    logic [2:0] int_flag_set;
  } sfr_periph_t;

  // Register contents steering the rest of the chip
  typedef struct packed {
    logic [7:0] options;
    logic [7:0] program_counter_low;
    logic [7:0] status;
    logic [7:0] pointer;
    logic [7:0] tris_a;
    logic [7:0] tris_b;
    logic [7:0] tris_c;
    logic [7:0] tris_d;
    logic [7:0] tris_e;
    logic [7:0] pc_latch;
    logic [7:0] int_ctl;
    logic [7:0] pie_one;
    logic [7:0] pie_two;
    logic [7:0] pwr_cause;
    logic [7:0] t2_period;
    logic [7:0] ssp_adr;
    logic [7:0] tx_ctl;
    logic [7:0] baud;
    logic [7:0] ana_cfg;
  } sfr_cfg_t;

endpackage

/* logic/sfr_bank1_map.sv */
// Bank 1 special register map: decode, storage, reset values and indirect access
//
// How it works
// - Unimplemented locations and bits read zero
// - Indirect port uses pointer, holds no storage
// - Shared registers answer from both banks
// - Program counter low byte, cleared every reset
// - Five-bit upper counter latch, cleared every reset
// - Direction registers reset to all ones, except port E at 07
// - Status reset value depends on power-up
// - Master clear and watchdog use other column
// - Bank select 01 maps direct access to bank 1
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "sfr_consts.svh"

module sfr_bank1_map (
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire sfr_pkg::sfr_bus_req_t bus,
  output logic [7:0]                rd_data,
  input  wire sfr_pkg::sfr_cause_t  cause,
  input  wire sfr_pkg::sfr_periph_t periph,
  output logic [8:0]                ext_addr,
  output logic [7:0]                ext_wdata,
  output logic                      ext_wr,
  output logic                      ext_rd,
  input  wire logic [7:0]           ext_rdata,
  output sfr_pkg::sfr_cfg_t         cfg
);

  // --------------------------------------------------------------------------
  // Storage limits per offset
  // --------------------------------------------------------------------------

  // Writable bits of each plain storage slot; zero means no storage
  function automatic logic [7:0] wmask(input logic [7:0] adr);
    unique case (adr)
      `SFR_ADR_OPTIONS, `SFR_ADR_PCL, `SFR_ADR_POINTER, `SFR_ADR_PORT_B_DIRECTION,
      `SFR_ADR_PORT_C_DIRECTION, `SFR_ADR_PORT_D_DIRECTION, `SFR_ADR_PIE_ONE, `SFR_ADR_T2PERIOD,
      `SFR_ADR_SSPADR, `SFR_ADR_BAUD: wmask = `SFR_WM_FULL;
      `SFR_ADR_PORT_A_DIRECTION:   wmask = `SFR_WM_PORT_A_DIRECTION;
      `SFR_ADR_PORT_E_DIRECTION_SLAVE_FLAGS:   wmask = `SFR_WM_PORT_E_DIRECTION_SLAVE_FLAGS;
      `SFR_ADR_PCLATCH: wmask = `SFR_WM_PCLATCH;
      `SFR_ADR_PIE_TWO: wmask = `SFR_WM_PIE_TWO;
      `SFR_ADR_TXCTL:   wmask = `SFR_WM_TXCTL;
      `SFR_ADR_ANACFG:  wmask = `SFR_WM_ANACFG;
      default:          wmask = `SFR_WM_NONE;
    endcase
  endfunction

  // Reset value of each plain storage slot, same for every reset
  function automatic logic [7:0] rstval(input logic [7:0] adr);
    unique case (adr)
      `SFR_ADR_OPTIONS, `SFR_ADR_PORT_B_DIRECTION, `SFR_ADR_PORT_C_DIRECTION, `SFR_ADR_PORT_D_DIRECTION,
      `SFR_ADR_T2PERIOD: rstval = `SFR_RST_ONES;
      `SFR_ADR_PORT_A_DIRECTION:    rstval = `SFR_RST_PORT_A_DIRECTION;
      `SFR_ADR_PORT_E_DIRECTION_SLAVE_FLAGS:    rstval = `SFR_RST_PORT_E_DIRECTION_SLAVE_FLAGS;
      `SFR_ADR_TXCTL:    rstval = `SFR_RST_TXCTL;
      default:           rstval = `SFR_RST_ZERO;
    endcase
  endfunction

  // Offsets whose copy also answers in bank 0
  function automatic logic mirrored(input logic [7:0] adr);
    mirrored = (adr == `SFR_ADR_INDIRECT) || (adr == `SFR_ADR_PCL) ||
               (adr == `SFR_ADR_STATUS) || (adr == `SFR_ADR_POINTER) ||
               (adr == `SFR_ADR_PCLATCH) || (adr == `SFR_ADR_INTCTL);
  endfunction

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  logic [7:0] slot [32];
  logic [4:0] status_ctl;   // Indirect bank, two bank bits, timeout, power-down
  logic [2:0] alu_flags;    // Zero, digit carry, carry: kept through resets
  logic [7:0] int_ctl;
  logic [1:0] pwr_bits;
  logic       rst_seen;
  logic [7:0] rd_q;
  logic       rd_ext_q;

  wire        is_indirect = (bus.addr == 7'h00);
  wire [8:0]  eff_addr    = is_indirect ? {status_ctl[4], slot[4]}
                                        : {status_ctl[3:2], bus.addr};
  wire [7:0]  loc_addr    = {1'b1, eff_addr[6:0]};
  wire [4:0]  loc_idx     = eff_addr[4:0];
  wire        in_bank1    = (eff_addr[8:7] == `SFR_BANK_ONE) &&
                            (eff_addr[6:5] == 2'b00);
  wire        in_bank0_mir = (eff_addr[8:7] == `SFR_BANK_ZERO) &&
                             mirrored(loc_addr);
  wire        ours        = in_bank1 || in_bank0_mir;
  // The indirect port pointing at itself has nothing behind it
  wire        self_ref    = ours && (loc_addr == `SFR_ADR_INDIRECT);
  wire        loc_wr      = bus.wr && ours && !self_ref;
  wire        hit_status  = loc_addr == `SFR_ADR_STATUS;
  wire        hit_intctl  = loc_addr == `SFR_ADR_INTCTL;
  wire        hit_pwr     = loc_addr == `SFR_ADR_PWRCAUSE;
  wire        first_col   = cause.power_on || cause.brown_out;

  // Everything outside this bank goes straight to data memory
  assign ext_addr  = eff_addr;
  assign ext_wdata = bus.wdata;
  assign ext_wr    = bus.wr && !ours;
  assign ext_rd    = bus.rd && !ours;

  // --------------------------------------------------------------------------
  // Plain storage slots
  // --------------------------------------------------------------------------

  // Only writable bits ever change; masked-out slots synthesise to constants
  for (genvar i = 0; i < 32; i++) begin : g_slot
    localparam logic [7:0] ADR = {3'b100, 5'(i)};
    localparam logic [7:0] WM  = wmask(ADR);
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        slot[i] <= rstval(ADR) & WM;
      end else if (loc_wr && loc_idx == 5'(i)) begin
        slot[i] <= (slot[i] & ~WM) | (bus.wdata & WM);
      end
    end
  end

  // --------------------------------------------------------------------------
  // Status register
  // --------------------------------------------------------------------------

  // Bank bits and the two cause bits; the cause bits are fixed up on the
  // first edge after release since an async reset may only load constants
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_ctl <= `SFR_RST_STATUS_CTL;
    end else if (!rst_seen && !first_col) begin
      status_ctl[1] <= !cause.watchdog;
      status_ctl[0] <= !cause.sleep;
    end else if (loc_wr && hit_status) begin
      status_ctl[4:2] <= bus.wdata[7:5];
    end
  end

  // Arithmetic flags have no reset so that they survive a non-power reset
  always_ff @(posedge clk) begin
    if (loc_wr && hit_status) begin
      alu_flags <= bus.wdata[2:0];
    end
  end

  // One-shot marker of the first edge after reset release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_seen <= 1'b0;
    end else begin
      rst_seen <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt control and reset cause bits
  // --------------------------------------------------------------------------

  // A flag raised in the cycle software clears it stays set
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      int_ctl <= `SFR_RST_ZERO;
    end else if (loc_wr && hit_intctl) begin
      int_ctl <= bus.wdata | {5'h00, periph.int_flag_set};
    end else begin
      int_ctl <= int_ctl | {5'h00, periph.int_flag_set};
    end
  end

  // Power and brown-out markers keep their value over other resets
  always_ff @(posedge clk) begin
    if (!rst_seen && first_col) begin
      pwr_bits <= {!cause.power_on, !cause.brown_out};
    end else if (loc_wr && hit_pwr) begin
      pwr_bits <= bus.wdata[1:0];
    end
  end

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  wire [7:0] status_rd = {status_ctl, alu_flags};
  wire [7:0] port_e_direction_slave_flags_rd  = slot[9] | {periph.psp_in_full, periph.psp_out_full, 6'h00};
  wire [7:0] txctl_rd  = (slot[24] & `SFR_WM_TXCTL) |
                         {6'h00, periph.tx_shift_empty, 1'b0};
  wire [7:0] sspst_rd  = {2'b00, periph.ssp_state};
  wire [7:0] pwr_rd    = {6'h00, pwr_bits};
  wire [7:0] slot_rd   = slot[loc_idx];
  wire [7:0] loc_rd    = self_ref               ? 8'h00 :
                         (loc_addr == `SFR_ADR_STATUS)   ? status_rd :
                         (loc_addr == `SFR_ADR_INTCTL)   ? int_ctl :
                         (loc_addr == `SFR_ADR_PWRCAUSE) ? pwr_rd :
                         (loc_addr == `SFR_ADR_PORT_E_DIRECTION_SLAVE_FLAGS)    ? port_e_direction_slave_flags_rd :
                         (loc_addr == `SFR_ADR_TXCTL)    ? txctl_rd :
                         (loc_addr == `SFR_ADR_SSPSTATE) ? sspst_rd :
                         slot_rd;

  // Read data stand in the cycle after the strobe only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_q     <= 8'h00;
      rd_ext_q <= 1'b0;
    end else begin
      rd_q     <= (bus.rd && ours) ? loc_rd : 8'h00;
      rd_ext_q <= bus.rd && !ours;
    end
  end

  assign rd_data = rd_ext_q ? ext_rdata : rd_q;

  // --------------------------------------------------------------------------
  // Register contents out to the chip
  // --------------------------------------------------------------------------
  assign cfg.options   = slot[1];
  assign cfg.program_counter_low       = slot[2];
  assign cfg.status    = status_rd;
  assign cfg.pointer   = slot[4];
  assign cfg.tris_a    = slot[5];
  assign cfg.tris_b    = slot[6];
  assign cfg.tris_c    = slot[7];
  assign cfg.tris_d    = slot[8];
  assign cfg.tris_e    = port_e_direction_slave_flags_rd;
  assign cfg.pc_latch  = slot[10];
  assign cfg.int_ctl   = int_ctl;
  assign cfg.pie_one   = slot[12];
  assign cfg.pie_two   = slot[13];
  assign cfg.pwr_cause = pwr_rd;
  assign cfg.t2_period = slot[18];
  assign cfg.ssp_adr   = slot[19];
  assign cfg.tx_ctl    = txctl_rd;
  assign cfg.baud      = slot[25];
  assign cfg.ana_cfg   = slot[31];

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  wire unimpl_loc = in_bank1 && (wmask(loc_addr) == 8'h00) && !self_ref &&
                    !hit_status && !hit_intctl && !hit_pwr &&
                    (loc_addr != `SFR_ADR_SSPSTATE);

  // Software-held state only; live peripheral bits may move during a hole write
  wire [148:0] held_view = {slot[1], slot[2], slot[4], slot[5], slot[6], slot[7],
                            slot[8], slot[9], slot[10], slot[12], slot[13], slot[18],
                            slot[19], slot[24], slot[25], slot[31], status_rd, pwr_rd,
                            int_ctl[7:3]};

  property p_unimpl_read;
    @(posedge clk) disable iff (!arst_n)
    (bus.rd && unimpl_loc) |=> (rd_data == 8'h00);
  endproperty
  a_unimpl_read: assert property (p_unimpl_read)
    else $error("unimplemented read not zero");

  property p_indirect_route;
    @(posedge clk) disable iff (!arst_n)
    (bus.rd && is_indirect) |-> (ext_rd == !ours) && (ext_addr == {status_ctl[4], slot[4]});
  endproperty
  a_indirect_route: assert property (p_indirect_route)
    else $error("indirect address wrong");

  property p_mirror_pcl;
    @(posedge clk) disable iff (!arst_n)
    (bus.wr && bus.addr == 7'h02 && status_ctl[3:2] == `SFR_BANK_ZERO)
      |=> (cfg.program_counter_low == $past(bus.wdata));
  endproperty
  a_mirror_pcl: assert property (p_mirror_pcl)
    else $error("bank 0 alias missed pcl");

  property p_pcl_reset;
    @(posedge clk) disable iff (!arst_n)
    !rst_seen |-> (cfg.program_counter_low == 8'h00) && (cfg.pc_latch == 8'h00);
  endproperty
  a_pcl_reset: assert property (p_pcl_reset)
    else $error("counter bytes not cleared");

  property p_latch_width;
    @(posedge clk) disable iff (!arst_n)
    (loc_wr && loc_addr == `SFR_ADR_PCLATCH)
      |=> (cfg.pc_latch == ($past(bus.wdata) & `SFR_WM_PCLATCH));
  endproperty
  a_latch_width: assert property (p_latch_width)
    else $error("latch not five bits");

  property p_dir_reset;
    @(posedge clk) disable iff (!arst_n)
    !rst_seen |-> (cfg.tris_a == `SFR_RST_PORT_A_DIRECTION) && (cfg.tris_b == `SFR_RST_ONES) &&
                  (cfg.tris_c == `SFR_RST_ONES) && (cfg.tris_d == `SFR_RST_ONES);
  endproperty
  a_dir_reset: assert property (p_dir_reset)
    else $error("direction reset wrong");

  property p_status_por;
    @(posedge clk) disable iff (!arst_n)
    (!rst_seen && first_col && !(loc_wr && hit_status)) |=> (cfg.status[7:3] == 5'b00011);
  endproperty
  a_status_por: assert property (p_status_por)
    else $error("power-up status wrong");

  property p_status_other;
    @(posedge clk) disable iff (!arst_n)
    (!rst_seen && !first_col) |=>
      (cfg.status[`SFR_ST_TIMEOUT] == !$past(cause.watchdog)) &&
      (cfg.status[`SFR_ST_POWERDOWN] == !$past(cause.sleep));
  endproperty
  a_status_other: assert property (p_status_other)
    else $error("other reset status wrong");

  property p_bank_one;
    @(posedge clk) disable iff (!arst_n)
    (bus.wr && bus.addr == 7'h05 && status_ctl[3:2] == `SFR_BANK_ONE)
      |=> (cfg.tris_a == ($past(bus.wdata) & `SFR_WM_PORT_A_DIRECTION)) && !$past(ext_wr);
  endproperty
  a_bank_one: assert property (p_bank_one)
    else $error("bank 1 write not decoded");

  property p_unimpl_write;
    @(posedge clk) disable iff (!arst_n)
    (bus.wr && unimpl_loc && rst_seen) |=> $stable(held_view);
  endproperty
  a_unimpl_write: assert property (p_unimpl_write)
    else $error("unimplemented write changed state");

  property p_self_write;
    @(posedge clk) disable iff (!arst_n)
    (bus.wr && self_ref && rst_seen) |-> !ext_wr ##1 $stable(held_view);
  endproperty
  a_self_write: assert property (p_self_write)
    else $error("self-pointing write not dropped");

  property p_intctl_mirror;
    @(posedge clk) disable iff (!arst_n)
    (bus.wr && bus.addr == 7'h0b && status_ctl[3:2] == `SFR_BANK_ZERO)
      |=> (cfg.int_ctl == ($past(bus.wdata) | {5'h00, $past(periph.int_flag_set)}));
  endproperty
  a_intctl_mirror: assert property (p_intctl_mirror)
    else $error("bank 0 alias missed interrupt control");

  property p_dir_e_reset;
    @(posedge clk) disable iff (!arst_n)
    !rst_seen |-> (cfg.tris_e[5:0] == 6'h07);
  endproperty
  a_dir_e_reset: assert property (p_dir_e_reset)
    else $error("port e direction reset wrong");

  property p_status_locked;
    @(posedge clk) disable iff (!arst_n)
    (loc_wr && hit_status && rst_seen) |=> (cfg.status[4:3] == $past(cfg.status[4:3]));
  endproperty
  a_status_locked: assert property (p_status_locked)
    else $error("status cause bits written");

  property p_upper_half;
    @(posedge clk) disable iff (!arst_n)
    (bus.rd && !is_indirect && status_ctl[3:2] == `SFR_BANK_ONE && bus.addr[6:5] != 2'b00)
      |-> ext_rd && (ext_addr == {`SFR_BANK_ONE, bus.addr});
  endproperty
  a_upper_half: assert property (p_upper_half)
    else $error("upper bank 1 half not sent out");

  c_indirect_ext: cover property (@(posedge clk) disable iff (!arst_n)
    bus.rd && is_indirect && !ours);
  c_status_write: cover property (@(posedge clk) disable iff (!arst_n)
    loc_wr && hit_status);
  c_flag_race: cover property (@(posedge clk) disable iff (!arst_n)
    loc_wr && hit_intctl && periph.int_flag_set != 3'h0);
  c_other_reset: cover property (@(posedge clk) disable iff (!arst_n)
    !rst_seen && cause.watchdog && !first_col);
  c_upper_half: cover property (@(posedge clk) disable iff (!arst_n)
    bus.rd && ext_rd && status_ctl[3:2] == `SFR_BANK_ONE);

endmodule

/* tb/sfr_bank1_map_test.sv */
// Self-checking bench for the bank 1 special register map
`timescale 1ns/1ps
`include "sfr_consts.svh"

module sfr_bank1_map_test;
  logic                  clk;
  logic                  arst_n;
  sfr_pkg::sfr_bus_req_t bus;
  logic [7:0]            rd_data;
  sfr_pkg::sfr_cause_t   cause;
  sfr_pkg::sfr_periph_t  periph;
  logic [8:0]            ext_addr;
  logic [7:0]            ext_wdata;
  logic                  ext_wr;
  logic                  ext_rd;
  logic [7:0]            ext_rdata;
  sfr_pkg::sfr_cfg_t     cfg;
  int                    fail_count;
  int                    num_checks;
  int                    cycles;
  logic [7:0]            got;
  logic [7:0]            got_wdata;
  logic [8:0]            got_addr;
  logic                  got_strobe;

  // Offset and expected value after power-on, status with bank 01 written
  localparam logic [14:0] RST_TAB [0:17] = '{
    {7'h01, 8'hff}, {7'h02, 8'h00}, {7'h05, 8'h3f}, {7'h06, 8'hff}, {7'h07, 8'hff},
    {7'h08, 8'hff}, {7'h09, 8'h07}, {7'h0a, 8'h00}, {7'h0b, 8'h00}, {7'h0c, 8'h00},
    {7'h0d, 8'h00}, {7'h0e, 8'h01}, {7'h12, 8'hff}, {7'h13, 8'h00}, {7'h14, 8'h00},
    {7'h18, 8'h02}, {7'h19, 8'h00}, {7'h03, 8'h38}};
  // Offset and value read back after writing all ones
  localparam logic [14:0] BIT_TAB [0:4] = '{
    {7'h05, 8'h3f}, {7'h0a, 8'h1f}, {7'h0d, 8'h01}, {7'h1f, 8'h07}, {7'h09, 8'h37}};
  localparam logic [6:0]  HOLE_TAB [0:10] = '{
    7'h0f, 7'h10, 7'h11, 7'h15, 7'h16, 7'h17, 7'h1a, 7'h1b, 7'h1c, 7'h1d, 7'h1e};

  sfr_bank1_map u_dut (
    .clk       (clk),
    .arst_n    (arst_n),
    .bus       (bus),
    .rd_data   (rd_data),
    .cause     (cause),
    .periph    (periph),
    .ext_addr  (ext_addr),
    .ext_wdata (ext_wdata),
    .ext_wr    (ext_wr),
    .ext_rd    (ext_rd),
    .ext_rdata (ext_rdata),
    .cfg       (cfg)
  );

  // ----------------------------------------------------------------------------
  // Clock, data memory stand-in and hang guard
  // ----------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Answers only the cycle after a strobe; otherwise toggles so stale data never matches
  always @(posedge clk) begin
    ext_rdata <= ext_rd ? 8'hc3 : ~ext_rdata;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      fail_count = fail_count + 1;
      close_out();
    end
  end

  // ----------------------------------------------------------------------------
  // Compare, bus and reset tasks
  // ----------------------------------------------------------------------------
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] seen);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk_addr(input string what, input logic [8:0] exp, input logic [8:0] seen);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic seen);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("wrong value %s expected %b seen %b", what, exp, seen);
    end
  endtask

  // One idle cycle between requests keeps each strobe assigned once per step
  task automatic bus_write(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge clk);
    got_strobe = ext_wr;
    got_addr   = ext_addr;
    got_wdata  = ext_wdata;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic bus_read(input logic [6:0] a);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(negedge clk);
    got_strobe = ext_rd;
    got_addr   = ext_addr;
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    got = rd_data;
  endtask

  task automatic rd_chk(input string what, input logic [6:0] a, input logic [7:0] exp);
    bus_read(a);
    chk_byte(what, exp, got);
  endtask

  // Cause stays put across release since it is sampled one edge later
  task automatic do_reset(input sfr_pkg::sfr_cause_t c);
    @(posedge clk);
    arst_n <= 1'b0;
    cause  <= c;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic close_out;
    if (fail_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_power_reset;
    bus_write(7'h03, 8'h20);
    for (int i = 0; i < 18; i++) begin
      rd_chk("reset value", RST_TAB[i][14:8], RST_TAB[i][7:0]);
    end
  endtask

  task automatic t_unimpl;
    for (int i = 0; i < 11; i++) begin
      bus_write(HOLE_TAB[i], 8'hff);
      chk_bit("hole ext write", 1'b0, got_strobe);
      rd_chk("hole read", HOLE_TAB[i], 8'h00);
    end
    for (int i = 0; i < 5; i++) begin
      bus_write(BIT_TAB[i][14:8], 8'hff);
      rd_chk("masked bits", BIT_TAB[i][14:8], BIT_TAB[i][7:0]);
    end
    bus_write(7'h08, 8'h00);
    bus_write(7'h09, 8'h00);
    rd_chk("absent port cleared", 7'h09, 8'h00);
    bus_write(7'h1f, 8'h00);
    rd_chk("absent converter cleared", 7'h1f, 8'h00);
  endtask

  task automatic t_mirror;
    bus_write(7'h04, 8'h3c);
    bus_write(7'h02, 8'h5a);
    bus_write(7'h0a, 8'h11);
    bus_write(7'h0b, 8'hc0);
    bus_read(7'h05);
    chk_bit("bank1 local read", 1'b0, got_strobe);
    bus_read(7'h25);
    chk_bit("bank1 upper ext", 1'b1, got_strobe);
    chk_addr("bank1 upper addr", 9'h0a5, got_addr);
    chk_byte("bank1 upper data", 8'hc3, got);
    bus_write(7'h03, 8'h00);
    rd_chk("pointer bank0", 7'h04, 8'h3c);
    rd_chk("pcl bank0", 7'h02, 8'h5a);
    rd_chk("latch bank0", 7'h0a, 8'h11);
    rd_chk("intctl bank0", 7'h0b, 8'hc0);
    rd_chk("status bank0", 7'h03, 8'h18);
    bus_read(7'h05);
    chk_bit("bank0 ext read", 1'b1, got_strobe);
    chk_addr("bank0 ext addr", 9'h005, got_addr);
    chk_byte("bank0 ext data", 8'hc3, got);
    bus_write(7'h05, 8'h96);
    chk_bit("bank0 ext write", 1'b1, got_strobe);
    chk_byte("bank0 ext wdata", 8'h96, got_wdata);
    @(posedge clk);
    periph.int_flag_set <= 3'b101;
    @(posedge clk);
    periph.int_flag_set <= 3'b000;
    @(negedge clk);
    chk_byte("flag set", 8'hc5, cfg.int_ctl);
    // A set pulse in the cycle of a clear must survive it
    @(posedge clk);
    bus <= '{addr: 7'h0b, wdata: 8'h00, wr: 1'b1, rd: 1'b0};
    periph.int_flag_set <= 3'b010;
    @(posedge clk);
    bus.wr <= 1'b0;
    periph.int_flag_set <= 3'b000;
    @(negedge clk);
    chk_byte("flag race", 8'h02, cfg.int_ctl);
    bus_write(7'h03, 8'h20);
  endtask

  task automatic t_indirect;
    bus_write(7'h04, 8'h20);
    bus_read(7'h00);
    chk_bit("ind ext read", 1'b1, got_strobe);
    chk_addr("ind addr", 9'h020, got_addr);
    chk_byte("ind data", 8'hc3, got);
    bus_write(7'h00, 8'h6b);
    chk_bit("ind ext write", 1'b1, got_strobe);
    chk_byte("ind wdata", 8'h6b, got_wdata);
    bus_write(7'h04, 8'h80);
    bus_write(7'h00, 8'hff);
    chk_bit("self write", 1'b0, got_strobe);
    rd_chk("self read", 7'h00, 8'h00);
    bus_write(7'h04, 8'h85);
    rd_chk("ind to dir reg", 7'h00, 8'h3f);
  endtask

  // Software leaves the low status bits as 101 so that kept bits are visible
  task automatic t_other_resets;
    bus_write(7'h03, 8'h25);
    bus_write(7'h02, 8'h55);
    bus_write(7'h0a, 8'h1f);
    bus_write(7'h06, 8'h00);
    bus_write(7'h05, 8'h00);
    do_reset(4'b0010);
    chk_byte("status wdt", 8'h0d, cfg.status);
    chk_byte("pcl wdt", 8'h00, cfg.program_counter_low);
    chk_byte("latch wdt", 8'h00, cfg.pc_latch);
    chk_byte("port_b_direction wdt", 8'hff, cfg.tris_b);
    chk_byte("port_a_direction wdt", 8'h3f, cfg.tris_a);
    chk_byte("cause wdt", 8'h01, cfg.pwr_cause);
    bus_write(7'h03, 8'h05);
    do_reset(4'b0001);
    rd_chk("status master_clear_pin", 7'h03, 8'h15);
    do_reset(4'b0100);
    chk_byte("status bor", 8'h1d, cfg.status);
    chk_byte("cause bor", 8'h02, cfg.pwr_cause);
  endtask

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    arst_n     = 1'b0;
    bus        = '0;
    cause      = 4'b1000;
    periph     = '0;
    periph.tx_shift_empty = 1'b1;
    ext_rdata  = 8'h3c;
    fail_count = 0;
    num_checks = 0;
    cycles     = 0;
    do_reset(4'b1000);
    t_power_reset();
    t_unimpl();
    t_mirror();
    t_indirect();
    t_other_resets();
    close_out();
  end
endmodule
